// File: rtl/pattern_gen.sv
// Test pattern source for the trace data pins
`timescale 1ns/10ps
`default_nettype none

module pattern_gen #(
	parameter int PW = 8
) (
	input  wire logic          i_clk,
	input  wire logic          i_nrst,
	input  wire logic          i_en,
	input  wire logic [3:0]    i_sel,
	output logic    [PW-1:0]   o_data
);
	logic            phase_r;
	logic [PW-1:0]   walk_r;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			phase_r <= 1'b0;
			walk_r  <= {{(PW-1){1'b0}}, 1'b1};
		end else if (!i_en) begin
			phase_r <= 1'b0;
			walk_r  <= {{(PW-1){1'b0}}, 1'b1};
		end else begin
			phase_r <= ~phase_r;
			walk_r  <= {walk_r[PW-2:0], walk_r[PW-1]};
		end
	end

	// Highest selected pattern wins so the capture side sees one sequence
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_data <= '0;
		end else if (!i_en) begin
			o_data <= '0;
		end else if (i_sel[3]) begin
			o_data <= phase_r ? {PW{1'b0}} : {PW{1'b1}};
		end else if (i_sel[2]) begin
			o_data <= phase_r ? {(PW/2){2'b01}} : {(PW/2){2'b10}};
		end else if (i_sel[1]) begin
			o_data <= ~walk_r;
		end else if (i_sel[0]) begin
			o_data <= walk_r;
		end else begin
			o_data <= '0;
		end
	end

endmodule : pattern_gen

`default_nettype wire

// File: rtl/scale_stage.sv
// One power-of-two prescaler stage of the trigger delay chain
`timescale 1ns/10ps
`default_nettype none

module scale_stage #(
	parameter int W = 1
) (
	input  wire logic i_clk,
	input  wire logic i_nrst,
	input  wire logic i_en,
	input  wire logic i_clear,
	input  wire logic i_tick,
	output logic      o_tick
);
	logic [W-1:0] cnt_r;

	// Divides by 2**W when enabled; a disabled stage is a plain wire
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_r <= '0;
		end else if (i_clear) begin
			cnt_r <= '0;
		end else if (i_tick && i_en) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	assign o_tick = i_en ? (i_tick && (&cnt_r)) : i_tick;

endmodule : scale_stage

`default_nettype wire

// File: rtl/trace_trigger_delay_counter.sv
// Trace trigger delay counter with scale chain and pattern capability
//
// Behaviour
// RQ1 - Hold an 8-bit preset: formatter words output before the trigger mark.
// RQ2 - Preset resets to zero; zero preset means the trigger is shown at once.
// RQ3 - After trigger start, wait preset times multiplier words, then mark.
// RQ4 - When the running count reaches zero it reloads from the preset.
// RQ5 - Writing the preset resets the running count; stages keep their state.
// RQ6 - Reading the preset register returns the preset, never the live count.
// RQ7 - Software should pair the short 8-bit preset with the multipliers.
// RQ8 - Multiplier stages may be combined, giving one up to about 2e9.
// RQ9 - Multiplier select resets to zero; no stage enabled means times one.
// RQ10 - Writing multiplier select reloads the count and clears every stage.
// RQ11 - Select bits 4, 3, 2 scale by 65536, 256, 16; clear disables.
// RQ12 - Select bits 1 and 0 scale by 4 and 2; clear disables.
// RQ13 - Capability bit 17 shows continuous mode, bit 16 timed mode.
// RQ14 - Capability bits 3..0 show FF/00, AA/55, walking zeros, walking ones.
// RQ15 - Supported test patterns can be driven on the trace data pins.
// RQ16 - Status shows running (count not zero) and fired (count reached zero).
// RQ17 - Read-only register shows implemented stages and the 8-bit counter.
// RQ18 - Count one per formatter word after start; mark when scaled count ends.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "trig_delay_cfg.svh"

module trace_trigger_delay_counter #(
	parameter logic [4:0] STAGE_CAP = 5'h1F,
	parameter logic       CNT8_CAP  = 1'b1,
	parameter logic [3:0] PAT_CAP   = 4'hF,
	parameter logic       CONT_CAP  = 1'b1,
	parameter logic       TIMED_CAP = 1'b0,
	parameter int         PW        = 8
) (
	input  wire logic                      i_clk,
	input  wire logic                      i_nrst,
	input  wire trig_delay_pkg::reg_req_t  i_req,
	output logic [`TDC_DATA_W-1:0]         o_rdata,
	input  wire logic                      i_word_strobe,
	input  wire logic                      i_trig_start,
	output logic                           o_trigger,
	output logic                           o_running,
	output logic                           o_fired,
	output logic [PW-1:0]                  o_pattern
);
	import trig_delay_pkg::*;

	// ==================================================================
	// Declarations
	localparam int NSTG = `TDC_SCALE_W;

	logic [`TDC_PRESET_W-1:0]  preset_r;
	logic [`TDC_SCALE_W-1:0]   scale_r;
	logic [`TDC_PAT_W-1:0]     pat_sel_r;
	logic                      pat_cont_r;
	logic [`TDC_PRESET_W-1:0]  cnt_r;
	logic [`TDC_DATA_W-1:0]    rdata_r;
	logic                      trigger_r;
	dly_state_t                state_r;
	logic [NSTG:0]             tick;
	logic                      wr_preset;
	logic                      wr_scale;
	logic                      wr_pat;
	logic                      start_ok;
	logic                      running;
	logic                      final_tick;
	logic                      expire;
	logic                      stage_clear;
	logic [`TDC_DATA_W-1:0]    trig_cap_word;
	logic [`TDC_DATA_W-1:0]    pat_cap_word;

	// ==================================================================
	// Register decode
	assign wr_preset = i_req.wr && (i_req.addr == `TDC_OFS_PRESET);
	assign wr_scale  = i_req.wr && (i_req.addr == `TDC_OFS_SCALE);
	assign wr_pat    = i_req.wr && (i_req.addr == `TDC_OFS_PAT_CTRL);

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			preset_r <= `TDC_PRESET_RST;                    // see RQ2
		end else if (wr_preset) begin
			preset_r <= i_req.wdata[`TDC_PRESET_W-1:0];     // see RQ1
		end
	end

	// Unimplemented stages cannot be turned on
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			scale_r <= `TDC_SCALE_RST;                      // see RQ9
		end else if (wr_scale) begin
			scale_r <= i_req.wdata[`TDC_SCALE_W-1:0] & STAGE_CAP;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			pat_sel_r  <= `TDC_PAT_RST;
			pat_cont_r <= 1'b0;
		end else if (wr_pat) begin
			pat_sel_r  <= i_req.wdata[`TDC_PAT_W-1:0] & PAT_CAP;
			pat_cont_r <= i_req.wdata[`TDC_BIT_PAT_CONT] & CONT_CAP;
		end
	end

	// ==================================================================
	// Read path: data valid in the cycle after the strobe only
	always_comb begin
		trig_cap_word = '0;
		trig_cap_word[`TDC_BIT_RUNNING] = running;        // see RQ16
		trig_cap_word[`TDC_BIT_FIRED]   = state_r == ST_FIRED;
		trig_cap_word[`TDC_BIT_CNT8]    = CNT8_CAP;       // see RQ17
		trig_cap_word[NSTG-1:0]         = STAGE_CAP;
	end

	always_comb begin
		pat_cap_word = '0;
		pat_cap_word[`TDC_BIT_PAT_CONT]  = CONT_CAP;      // see RQ13
		pat_cap_word[`TDC_BIT_PAT_TIMED] = TIMED_CAP;
		pat_cap_word[`TDC_PAT_W-1:0]     = PAT_CAP;       // see RQ14
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rdata_r <= '0;
		end else if (!i_req.rd) begin
			rdata_r <= '0;
		end else begin
			case (i_req.addr)
				`TDC_OFS_TRIG_CAP: rdata_r <= trig_cap_word;
				// Preset, not the live count
				`TDC_OFS_PRESET:   rdata_r <= {24'h000000, preset_r}; // see RQ6
				`TDC_OFS_SCALE:    rdata_r <= {27'h0000000, scale_r};
				`TDC_OFS_PAT_CAP:  rdata_r <= pat_cap_word;
				`TDC_OFS_PAT_CTRL: begin
					rdata_r <= '0;
					rdata_r[`TDC_BIT_PAT_CONT] <= pat_cont_r;
					rdata_r[`TDC_PAT_W-1:0]    <= pat_sel_r;
				end
				default:           rdata_r <= '0;
			endcase
		end
	end

	// ==================================================================
	// Scale chain: each enabled stage divides the word tick further
	assign running     = state_r == ST_RUN;
	assign start_ok    = i_trig_start && !running;
	assign stage_clear = wr_scale || start_ok;              // see RQ10
	assign tick[0]     = i_word_strobe && running;          // see RQ18

	genvar g;
	generate
		for (g = 0; g < NSTG; g++) begin : g_stage
			// Widths 1,2,4,8,16 give x2, x4, x16, x256, x65536
			scale_stage #(
				.W (1 << g)
			) u_stage (
				.i_clk   (i_clk),
				.i_nrst  (i_nrst),
				.i_en    (scale_r[g]),                      // see RQ11 RQ12
				.i_clear (stage_clear),
				.i_tick  (tick[g]),
				.o_tick  (tick[g+1])
			);
		end
	endgenerate

	// Stages multiply in series, so any mix of enables combines
	assign final_tick = tick[NSTG];                         // see RQ8
	// A preset rewritten to zero mid-run expires on the next tick
	assign expire     = running && final_tick && (cnt_r <= 8'h01);

	// ==================================================================
	// Word counter
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_r <= `TDC_PRESET_RST;
		end else if (wr_preset) begin
			cnt_r <= i_req.wdata[`TDC_PRESET_W-1:0];       // see RQ5
		end else if (wr_scale || start_ok) begin
			cnt_r <= preset_r;                              // see RQ10
		end else if (expire) begin
			cnt_r <= preset_r;                              // see RQ4
		end else if (running && final_tick) begin
			cnt_r <= cnt_r - 8'h01;                         // see RQ3
		end
	end

	// ==================================================================
	// Sequencer: a start while running is ignored
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE, ST_FIRED: begin
					if (i_trig_start) begin
						state_r <= (preset_r == 8'h00) ? ST_FIRED : ST_RUN; // see RQ2
					end
				end
				ST_RUN: begin
					if (expire) begin
						state_r <= ST_FIRED;                    // see RQ16
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			trigger_r <= 1'b0;
		end else begin
			trigger_r <= (start_ok && preset_r == 8'h00) || expire; // see RQ18
		end
	end

	// ==================================================================
	// Test pattern output
	pattern_gen #(
		.PW (PW)
	) u_pattern (
		.i_clk   (i_clk),
		.i_nrst  (i_nrst),
		.i_en    (pat_cont_r),
		.i_sel   (pat_sel_r),                               // see RQ15
		.o_data  (o_pattern)
	);

	assign o_rdata   = rdata_r;
	assign o_trigger = trigger_r;
	assign o_running = state_r[1];
	assign o_fired   = state_r[2];

	// ==================================================================
	// Checks
	AST_PRESET_READ: assert property ( // see RQ6
		@(posedge i_clk) disable iff (!i_nrst)
		(i_req.rd && i_req.addr == `TDC_OFS_PRESET && !i_req.wr)
		|=> o_rdata == {24'h000000, $past(preset_r)})
		else $error("preset readback differs from preset");

	AST_RDATA_IDLE: assert property ( // see RQ6
		@(posedge i_clk) disable iff (!i_nrst)
		!i_req.rd |=> o_rdata == 32'h0000_0000)
		else $error("read data stood outside its cycle");

	AST_ZERO_NODELAY: assert property ( // see RQ2
		@(posedge i_clk) disable iff (!i_nrst)
		(i_trig_start && !o_running && preset_r == 8'h00)
		|=> o_trigger && o_fired)
		else $error("zero preset did not fire at once");

	AST_PRESET_WRITE: assert property ( // see RQ5
		@(posedge i_clk) disable iff (!i_nrst)
		wr_preset |=> cnt_r == $past(i_req.wdata[7:0]))
		else $error("preset write did not reset the count");

	// Only idle word slots, since a counted word moves the stages anyway
	AST_STAGE_HOLD: assert property ( // see RQ5
		@(posedge i_clk) disable iff (!i_nrst)
		(wr_preset && !i_word_strobe && !start_ok)
		|=> $stable(g_stage[0].u_stage.cnt_r)
		 && $stable(g_stage[1].u_stage.cnt_r))
		else $error("preset write disturbed the multiplier stages");

	AST_SCALE_WRITE: assert property ( // see RQ10
		@(posedge i_clk) disable iff (!i_nrst)
		wr_scale |=> cnt_r == preset_r && g_stage[4].u_stage.cnt_r == 16'h0000)
		else $error("scale write did not reload and clear stages");

	AST_SCALE_MASK: assert property ( // see RQ11
		@(posedge i_clk) disable iff (!i_nrst)
		wr_scale |=> scale_r == ($past(i_req.wdata[4:0]) & STAGE_CAP))
		else $error("scale select not taken from the write");

	AST_RELOAD: assert property ( // see RQ4
		@(posedge i_clk) disable iff (!i_nrst)
		(expire && !i_req.wr) |=> cnt_r == preset_r && o_fired && o_trigger)
		else $error("expiry did not reload and fire");

	AST_UNITY_STEP: assert property ( // see RQ9
		@(posedge i_clk) disable iff (!i_nrst)
		(scale_r == 5'h00 && o_running && i_word_strobe && cnt_r > 8'h01
		 && !i_req.wr) |=> cnt_r == $past(cnt_r) - 8'h01)
		else $error("unscaled word did not step the count");

	AST_X2_STEP: assert property ( // see RQ12
		@(posedge i_clk) disable iff (!i_nrst)
		(scale_r == 5'h01 && o_running && !i_req.wr && i_word_strobe
		 && g_stage[0].u_stage.cnt_r == 1'b0) |=> $stable(cnt_r))
		else $error("x2 stage passed the first word");

	AST_TICK_CAUSE: assert property ( // see RQ18
		@(posedge i_clk) disable iff (!i_nrst)
		$changed(cnt_r) && !$past(i_req.wr) && !$past(start_ok)
		|-> $past(i_word_strobe) && $past(running))
		else $error("count moved without a formatter word");

	AST_TRIG_PULSE: assert property ( // see RQ18
		@(posedge i_clk) disable iff (!i_nrst)
		(o_trigger && !i_trig_start) |=> !o_trigger)
		else $error("trigger mark stood longer than one cycle");

	AST_RUN_HOLD: assert property ( // see RQ3
		@(posedge i_clk) disable iff (!i_nrst)
		(o_running && !expire) |=> o_running)
		else $error("running flag fell before the count expired");

	AST_FLAGS_EXCL: assert property ( // see RQ16
		@(posedge i_clk) disable iff (!i_nrst)
		$rose(o_fired) |-> o_trigger && !o_running)
		else $error("fired flag rose without the trigger mark");

	AST_FIRED_HOLD: assert property ( // see RQ16
		@(posedge i_clk) disable iff (!i_nrst)
		(o_fired && !i_trig_start) |=> o_fired)
		else $error("fired flag dropped without a new start");

	AST_CAP_WORD: assert property ( // see RQ13
		@(posedge i_clk) disable iff (!i_nrst)
		(i_req.rd && i_req.addr == `TDC_OFS_PAT_CAP)
		|=> o_rdata[17:16] == {CONT_CAP, TIMED_CAP} && o_rdata[3:0] == PAT_CAP)
		else $error("pattern capability word wrong");

endmodule : trace_trigger_delay_counter

`default_nettype wire

// File: shared/trig_delay_cfg.svh
// Register offsets, field positions, reset values for the trigger delay block
`ifndef TRIG_DELAY_CFG_SVH
`define TRIG_DELAY_CFG_SVH

// ==================================================================
// Bus geometry
`define TDC_ADDR_W         12
`define TDC_DATA_W         32

// ==================================================================
// Register byte offsets
`define TDC_OFS_TRIG_CAP   12'h100
`define TDC_OFS_PRESET     12'h104
`define TDC_OFS_SCALE      12'h108
`define TDC_OFS_PAT_CAP    12'h10C
`define TDC_OFS_PAT_CTRL   12'h110

// ==================================================================
// Field positions and widths
`define TDC_PRESET_W       8
`define TDC_SCALE_W        5
`define TDC_PAT_W          4
`define TDC_BIT_RUNNING    17
`define TDC_BIT_FIRED      16
`define TDC_BIT_CNT8       8
`define TDC_BIT_PAT_CONT   17
`define TDC_BIT_PAT_TIMED  16

// ==================================================================
// Reset values
`define TDC_PRESET_RST     8'h00
`define TDC_SCALE_RST      5'h00
`define TDC_PAT_RST        4'h0

`endif

// File: shared/trig_delay_pkg.sv
// Types shared by the trigger delay counter and its helpers
`include "trig_delay_cfg.svh"

package trig_delay_pkg;

	// ==================================================================
	// Register port request
	typedef struct packed {
		logic                     wr;
		logic                     rd;
		logic [`TDC_ADDR_W-1:0]   addr;
		logic [`TDC_DATA_W-1:0]   wdata;
	} reg_req_t;

	// ==================================================================
	// Delay sequencer states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_RUN   = 3'h2,
		ST_FIRED = 3'h4
	} dly_state_t;

endpackage : trig_delay_pkg

// File: verif/trace_capture_model.sv
// Trace capture device model: counts trigger marks, recognises test patterns
`timescale 1ns/10ps
`default_nettype none

module trace_capture_model (
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_trigger,
	input  wire logic [7:0]  i_data,
	output logic      [15:0] o_trig_total,
	output logic      [3:0]  o_kind
);
	logic [7:0] prev_r;
	logic [7:0] rl;
	logic [7:0] rr;

	// ==================================================================
	// Capture
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			prev_r       <= 8'h00;
			o_trig_total <= 16'h0000;
		end else begin
			prev_r       <= i_data;
			o_trig_total <= o_trig_total + {15'h0000, i_trigger};
		end
	end

	// ==================================================================
	// Recognition
	// A pattern is only claimed when two words in a row agree with it,
	// so a single stray word never looks like a test pattern
	assign rl = {prev_r[6:0], prev_r[7]};
	assign rr = {prev_r[0], prev_r[7:1]};
	always_comb begin
		o_kind[3] = (prev_r == ~i_data) && (i_data == 8'hFF || i_data == 8'h00);
		o_kind[2] = (prev_r == ~i_data) && (i_data == 8'hAA || i_data == 8'h55);
		o_kind[1] = (i_data == rl || i_data == rr) && ($countones(~i_data) == 1);
		o_kind[0] = (i_data == rl || i_data == rr) && ($countones(i_data) == 1);
	end
endmodule : trace_capture_model

`default_nettype wire

// File: verif/trace_trigger_delay_counter_test.sv
// Self-checking testbench for the trace trigger delay counter
`timescale 1ns/10ps
`default_nettype none
`include "trig_delay_cfg.svh"

module trace_trigger_delay_counter_test;
	import trig_delay_pkg::*;
	logic        i_clk;
	logic        i_nrst;
	reg_req_t    i_req;
	logic [31:0] o_rdata;
	logic        i_word_strobe;
	logic        i_trig_start;
	logic        o_trigger;
	logic        o_running;
	logic        o_fired;
	logic [7:0]  o_pattern;
	logic [15:0] trig_total;
	logic [3:0]  kind;
	logic [15:0] lf = 16'h8092;
	logic [31:0] rv;
	logic [39:0] cnt;
	logic [3:0]  pats [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
	int          err_total = 0;
	int          cmp_count = 0;

	trace_trigger_delay_counter i_dut (
		.i_clk(i_clk), .i_nrst(i_nrst), .i_req(i_req), .o_rdata(o_rdata),
		.i_word_strobe(i_word_strobe), .i_trig_start(i_trig_start),
		.o_trigger(o_trigger), .o_running(o_running), .o_fired(o_fired),
		.o_pattern(o_pattern)
	);

	trace_capture_model i_cap (
		.i_clk(i_clk), .i_nrst(i_nrst), .i_trigger(o_trigger),
		.i_data(o_pattern), .o_trig_total(trig_total), .o_kind(kind)
	);

	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	// ==================================================================
	// Helpers
	function automatic logic [15:0] nx(input logic [15:0] x);
		nx = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : nx

	function automatic logic [39:0] words(input logic [7:0] p, input logic [4:0] s);
		int sh [5] = '{1, 2, 4, 8, 16};
		words = 40'(p);
		for (int i = 0; i < 5; i++) begin
			if (s[i]) words = words << sh[i];
		end
	endfunction : words

	task automatic stop_test;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic done(input string n);
		$display("test %s finished", n);
	endtask : done

	// One bus cycle, then one idle cycle in which the read data stand
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		i_req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge i_clk);
		#1;
		rv = o_rdata;
		i_req <= '0;
		@(posedge i_clk);
		#1;
	endtask : bus

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(40'(rv), 40'(e));
	endtask : rd

	task automatic start;
		i_trig_start <= 1'b1;
		@(posedge i_clk);
		#1;
		i_trig_start <= 1'b0;
	endtask : start

	task automatic pulse(input int n);
		repeat (n) begin
			i_word_strobe <= 1'b1;
			@(posedge i_clk);
			#1;
		end
		i_word_strobe <= 1'b0;
	endtask : pulse

	// Counts words until the mark; gaps are random on short delays only,
	// the long ones stream to keep the run inside its cycle budget
	task automatic drain(input logic [39:0] e);
		int g;
		cnt = 40'h0;
		g = 0;
		while (o_trigger !== 1'b1 && g < 80000) begin
			lf = nx(lf);
			i_word_strobe <= (e > 40'd4096) | lf[0];
			@(posedge i_clk);
			cnt = cnt + 40'(i_word_strobe);
			#1;
			g++;
		end
		i_word_strobe <= 1'b0;
		chk(cnt, e);
	endtask : drain

	task automatic run(input logic [7:0] p, input logic [4:0] s, input logic w);
		logic [15:0] t0;
		t0 = trig_total;
		if (w) begin
			bus(1'b1, `TDC_OFS_PRESET, 32'(p));
			bus(1'b1, `TDC_OFS_SCALE, 32'(s));
		end
		start();
		if (p != 8'h00) chk(40'(o_running), 40'd1);
		drain(words(p, s));
		chk(40'({o_fired, o_running}), 40'd2);
		@(posedge i_clk);
		#1;
		chk(40'(o_trigger), 40'd0);
		chk(40'(trig_total), 40'(t0 + 16'h0001));
		rd(`TDC_OFS_PRESET, 32'(p));
	endtask : run

	// ==================================================================
	// Sequence
	initial begin
		i_nrst = 1'b0;
		i_req = '0;
		i_word_strobe = 1'b0;
		i_trig_start = 1'b0;
		repeat (4) @(posedge i_clk);
		#1;
		i_nrst <= 1'b1;
		@(posedge i_clk);
		#1;
		chk(40'({o_trigger, o_running, o_fired}), 40'd0);
		rd(`TDC_OFS_PRESET, 32'h0000_0000);
		rd(`TDC_OFS_SCALE, 32'h0000_0000);
		rd(`TDC_OFS_TRIG_CAP, 32'h0000_011F);
		rd(`TDC_OFS_PAT_CTRL, 32'h0000_0000);
		rd(`TDC_OFS_PAT_CAP, 32'h0002_000F);
		rd(12'h1FC, 32'h0000_0000);
		done("reset");
		bus(1'b1, `TDC_OFS_PRESET, 32'hFFFF_FFA5);
		rd(`TDC_OFS_PRESET, 32'h0000_00A5);
		bus(1'b1, `TDC_OFS_SCALE, 32'hFFFF_FFFF);
		rd(`TDC_OFS_SCALE, 32'h0000_001F);
		bus(1'b1, `TDC_OFS_PAT_CAP, 32'hFFFF_FFFF);
		rd(`TDC_OFS_PAT_CAP, 32'h0002_000F);
		bus(1'b1, 12'h1FC, 32'hFFFF_FFFF);
		rd(12'h1FC, 32'h0000_0000);
		done("registers");
		run(8'h00, 5'h1F, 1'b1);
		for (int i = 0; i < 4; i++) run(8'h03, 5'(1 << i), 1'b1);
		run(8'h03, 5'h08, 1'b0);
		run(8'h02, 5'h07, 1'b1);
		run(8'h01, 5'h10, 1'b1);
		run(8'h05, 5'h00, 1'b1);
		repeat (4) begin
			lf = nx(lf);
			run({4'h0, lf[3:0]}, {3'h0, lf[5:4]}, 1'b1);
		end
		done("delay");
		bus(1'b1, `TDC_OFS_PRESET, 32'h0000_0004);
		bus(1'b1, `TDC_OFS_SCALE, 32'h0000_0001);
		start();
		pulse(1);
		bus(1'b1, `TDC_OFS_PRESET, 32'h0000_0003);
		drain(40'd5);
		bus(1'b1, `TDC_OFS_PRESET, 32'h0000_0003);
		start();
		pulse(3);
		bus(1'b1, `TDC_OFS_SCALE, 32'h0000_0001);
		rd(`TDC_OFS_TRIG_CAP, 32'h0002_011F);
		rd(`TDC_OFS_PRESET, 32'h0000_0003);
		drain(40'd6);
		rd(`TDC_OFS_TRIG_CAP, 32'h0001_011F);
		done("mid-run");
		foreach (pats[i]) begin
			bus(1'b1, `TDC_OFS_PAT_CTRL, 32'h0002_0000 | 32'(pats[i]));
			repeat (2) @(posedge i_clk);
			#1;
			chk(40'(kind), 40'(pats[i]));
			rd(`TDC_OFS_PAT_CTRL, 32'h0002_0000 | 32'(pats[i]));
		end
		bus(1'b1, `TDC_OFS_PAT_CTRL, 32'h0000_0000);
		done("pattern");
		stop_test();
	end

	// Whole sequence needs about 70k cycles; cut off at 100k
	initial begin
		#2000000;
		err_total++;
		stop_test();
	end
endmodule : trace_trigger_delay_counter_test

`default_nettype wire
